/* File: verilog/uims_pkg.sv */
package uims_pkg;
	// register port offsets
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_IER = 3'h1;
	localparam logic [2:0] A_ISR = 3'h2;
	localparam logic [2:0] A_MCR = 3'h4;
	localparam logic [2:0] A_LSR = 3'h5;
	localparam logic [2:0] A_MSR = 3'h6;
	localparam logic [2:0] A_SPR = 3'h7;
	// indexed control offset held in scratch_byte
	localparam logic [7:0] CPR_IDX = 8'h01;
	localparam logic [7:0] CPR_RST = 8'h20;
	// M=1, N=0: divide by one
	localparam logic [7:0] CPR_DIV1 = 8'h08;
	localparam logic [15:0] DIV_RST = 16'h0001;
	// irq_source_reg codes
	localparam logic [5:0] ISR_NONE = 6'h01;
	localparam logic [5:0] ISR_L1 = 6'h06;
	localparam logic [5:0] ISR_L2A = 6'h04;
	localparam logic [5:0] ISR_L2B = 6'h0C;
	localparam logic [5:0] ISR_L3 = 6'h02;
	localparam logic [5:0] ISR_L4 = 6'h00;
	localparam logic [5:0] ISR_L5 = 6'h10;
	localparam logic [5:0] ISR_L6 = 6'h20;
	// irq_enable_reg bits
	localparam int IE_RX = 0;
	localparam int IE_TX = 1;
	localparam int IE_RLS = 2;
	localparam int IE_MS = 3;
	localparam int IE_SLP = 4;
	localparam int IE_SPC = 5;
	localparam int IE_RTS = 6;
	localparam int IE_CTS = 7;
	// modem_ctrl_reg bits
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_OUTA = 2;
	localparam int MC_OUTB = 3;
	localparam int MC_LOOP = 4;
	localparam int MC_XANY = 5;
	localparam int MC_IRDA = 6;
	localparam int MC_PSEL = 7;
	// synchroniser vector positions
	localparam int P_SIN = 0;
	localparam int P_CTS = 1;
	localparam int P_DSR = 2;
	localparam int P_RI = 3;
	localparam int P_DCD = 4;
	localparam int P_SEL = 5;
	localparam int TO_SHIFT = 2;

	typedef struct packed {
		logic [2:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} uims_req_t;

	typedef struct packed {
		logic ovr;
		logic par;
		logic frm;
		logic brk;
	} uims_rxerr_t;
endpackage

/* File: verilog/uims_core.sv */
`timescale 1ns/1ps
// Functional notes
// - normal mode: level 1 while line-status bits 1-4 set, enabled by ier bit 2
// - nine-bit: errors gated by ier bit 3, address bit by nmr bit 1
// - level 2a active while receive fill level exceeds its trigger
// - level 2b after four idle character periods with data in fifo mode
// - reading receive data clears the time-out
// - level 3 set when tx level drops below trigger, cleared by read or refill
// - trigger zero with extended levels waits for shifter empty and idle line
// - level 4 while any modem delta set; status read clears deltas
// - level 5 from stop or special character events, enhanced mode only
// - level 6 on clear or request pin rising, cleared by level 6 read
// - sleep only when requested and every idle condition holds
// - sleep bit reads actual state; wake when any condition fails
// - ready and request outputs active low from control bits 0 and 1
// - interrupt drive select low: control bit 3 enables the driver
// - loopback holds outputs high and routes outputs back internally
// - loopback modem sources are the low four control bits
// - deltas on any change, ring only on trailing edge, upper bits inverted
// - control bit 5 is xon-any in enhanced, hardware flow otherwise
// - control bit 6 selects infrared in enhanced mode and blocks sleep
// - control bit 7 selects prescaler; writable only in enhanced mode
// - divisor is low plus 256 times high; reset divisor one
// - scratch byte stored and used as indexed register offset
// - source register reports highest pending level or 000001
module uims_core #(
	parameter int LW = 8
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire uims_pkg::uims_req_t reg_req,
	input wire logic divisor_access,
	output logic [7:0] reg_rdata,
	input wire logic enhanced_mode,
	input wire logic fifo_mode,
	input wire logic nine_bit_mode,
	input wire logic nine_bit_addr_irq_en,
	input wire logic ext_trig_en,
	input wire logic inband_rx_en,
	input wire logic special_det_en,
	input wire logic [LW-1:0] rx_level,
	input wire logic [LW-1:0] rx_trig,
	input wire logic [LW-1:0] tx_level,
	input wire logic [LW-1:0] tx_trig,
	input wire logic tx_shift_empty,
	input wire logic tx_serial_bit,
	input wire logic rx_idle,
	input wire logic rx_push,
	input wire uims_pkg::uims_rxerr_t rx_err,
	input wire logic [15:0] char_ticks,
	input wire logic stop_char_evt,
	input wire logic second_stop_char_evt,
	input wire logic special_char_evt,
	input wire logic serial_rx_line,
	input wire logic clear_to_send_in_n,
	input wire logic data_set_ready_in_n,
	input wire logic bell_indicator_in,
	input wire logic carrier_detect_in,
	input wire logic irq_drive_select,
	output logic serial_tx_line,
	output logic local_terminal_ready_out,
	output logic request_to_send_out,
	output logic user_output_a,
	output logic user_output_b,
	output logic rx_serial_to_receiver,
	output logic irq_out,
	output logic irq_oe,
	output logic chan_asleep,
	output logic [15:0] baud_divisor,
	output logic [7:0] prescale_cfg,
	output logic xon_any_en,
	output logic hw_flow_en,
	output logic irda_en
);
	typedef struct packed {
		logic [5:0] pin_m;
		logic [5:0] pin_s;
		logic [7:0] irq_enable_reg;
		logic [7:0] modem_control;
		logic [7:0] dll;
		logic [7:0] divisor_high_byte;
		logic [7:0] scratch_pad;
		logic [7:0] clock_prescaler;
		logic [3:0] lsr_flg;
		logic lsr_err;
		logic [3:0] msr_d;
		logic [3:0] mdm_p;
		logic [LW+17:0] to_cnt;
		logic to_flg;
		logic tx_low_p;
		logic thre;
		logic l5;
		logic l6c;
		logic l6r;
		logic cts_p;
		logic rts_p;
		logic asleep;
		logic [7:0] rdata;
		logic irq;
		logic irq_oe;
		logic tx_line;
		logic dtr_n;
		logic rts_n;
		logic out_a;
		logic out_b;
		logic rx_line;
		logic [7:0] pre;
		logic [2:0] ctl;
	} uims_state_t;

	uims_state_t s_q;
	uims_state_t s_d;
	logic loop;
	logic rd_rhr;
	logic rd_isr;
	logic rd_lsr;
	logic rd_msr;
	logic [3:0] mdm;
	logic [3:0] mdm_evt;
	logic src1;
	logic src2a;
	logic src2b;
	logic src3;
	logic src4;
	logic src5;
	logic src6;
	logic [5:0] code;
	logic tx_low;
	logic slp_req;
	logic slp_ok;
	logic [LW+17:0] to_lim;

	assign loop = s_q.modem_control[uims_pkg::MC_LOOP];
	assign to_lim = {{LW{1'b0}}, char_ticks, 2'b00};

	always_comb begin
		s_d = s_q;
		rd_rhr = reg_req.rd && reg_req.addr == uims_pkg::A_DATA
			&& !divisor_access;
		rd_isr = reg_req.rd && reg_req.addr == uims_pkg::A_ISR;
		rd_lsr = reg_req.rd && reg_req.addr == uims_pkg::A_LSR;
		rd_msr = reg_req.rd && reg_req.addr == uims_pkg::A_MSR;
		s_d.pin_m = {irq_drive_select, carrier_detect_in, bell_indicator_in,
			data_set_ready_in_n, clear_to_send_in_n, serial_rx_line};
		s_d.pin_s = s_q.pin_m;

		// true (active) levels, order {dcd, ri, dsr, cts}
		if (loop) begin
			mdm = {s_q.modem_control[uims_pkg::MC_OUTB], s_q.modem_control[uims_pkg::MC_OUTA],
				s_q.modem_control[uims_pkg::MC_DTR], s_q.modem_control[uims_pkg::MC_RTS]};
		end else begin
			mdm = ~{s_q.pin_s[uims_pkg::P_DCD], s_q.pin_s[uims_pkg::P_RI],
				s_q.pin_s[uims_pkg::P_DSR], s_q.pin_s[uims_pkg::P_CTS]};
		end
		mdm_evt = mdm ^ s_q.mdm_p;
		mdm_evt[2] = s_q.mdm_p[2] && !mdm[2];
		s_d.mdm_p = mdm;

		// level 1
		if (nine_bit_mode) begin
			// flag order {brk, frm, par, ovr}; par carries the address bit
			src1 = ((s_q.lsr_flg[3] || s_q.lsr_flg[2] || s_q.lsr_flg[0])
				&& s_q.irq_enable_reg[uims_pkg::IE_MS])
				|| (s_q.lsr_flg[1] && nine_bit_addr_irq_en);
		end else begin
			src1 = (|s_q.lsr_flg) && s_q.irq_enable_reg[uims_pkg::IE_RLS];
		end
		src2a = rx_level > rx_trig && s_q.irq_enable_reg[uims_pkg::IE_RX];
		src2b = s_q.to_flg && s_q.irq_enable_reg[uims_pkg::IE_RX];
		src3 = s_q.thre && s_q.irq_enable_reg[uims_pkg::IE_TX];
		src4 = (|s_q.msr_d) && s_q.irq_enable_reg[uims_pkg::IE_MS];
		src5 = enhanced_mode && s_q.l5 && s_q.irq_enable_reg[uims_pkg::IE_SPC];
		src6 = enhanced_mode && ((s_q.l6c && s_q.irq_enable_reg[uims_pkg::IE_CTS])
			|| (s_q.l6r && s_q.irq_enable_reg[uims_pkg::IE_RTS]));

		if (src1) begin
			code = uims_pkg::ISR_L1;
		end else if (src2a) begin
			code = uims_pkg::ISR_L2A;
		end else if (src2b) begin
			code = uims_pkg::ISR_L2B;
		end else if (src3) begin
			code = uims_pkg::ISR_L3;
		end else if (src4) begin
			code = uims_pkg::ISR_L4;
		end else if (src5) begin
			code = uims_pkg::ISR_L5;
		end else if (src6) begin
			code = uims_pkg::ISR_L6;
		end else begin
			code = uims_pkg::ISR_NONE;
		end

		// line status flags: a new error in the read cycle survives
		s_d.lsr_flg = (rd_lsr ? 4'h0 : s_q.lsr_flg)
			| {rx_err.brk, rx_err.frm, rx_err.par, rx_err.ovr};
		s_d.lsr_err = (!rd_lsr && s_q.lsr_err) || rx_err.frm || rx_err.brk
			|| (!nine_bit_mode && rx_err.par);

		// time-out: rx_push marks the stop-bit centre of a new item
		if (rx_push || rd_rhr || rx_level == '0) begin
			s_d.to_cnt = '0;
		end else if (s_q.to_cnt != '1) begin
			s_d.to_cnt = s_q.to_cnt + 1'b1;
		end
		if (rd_rhr) begin
			s_d.to_flg = 1'b0;
		end else if (fifo_mode && rx_level != '0 && s_q.to_cnt > to_lim) begin
			s_d.to_flg = 1'b1;
		end

		// transmit empty
		if (ext_trig_en && tx_trig == '0) begin
			tx_low = tx_level == '0 && tx_shift_empty && tx_serial_bit;
		end else begin
			tx_low = tx_level < tx_trig;
		end
		s_d.tx_low_p = tx_low;
		if ((rd_isr && code == uims_pkg::ISR_L3) || tx_level > tx_trig) begin
			s_d.thre = 1'b0;
		end
		if (tx_low && !s_q.tx_low_p) begin
			s_d.thre = 1'b1;
		end

		if (rd_isr && code == uims_pkg::ISR_L5) begin
			s_d.l5 = 1'b0;
		end
		if (enhanced_mode && ((stop_char_evt && inband_rx_en)
			|| (second_stop_char_evt && special_det_en)
			|| (special_char_evt && nine_bit_mode))) begin
			s_d.l5 = 1'b1;
		end

		s_d.cts_p = s_q.pin_s[uims_pkg::P_CTS];
		s_d.rts_p = s_q.rts_n;
		if (rd_isr && code == uims_pkg::ISR_L6) begin
			s_d.l6c = 1'b0;
			s_d.l6r = 1'b0;
		end
		if (s_q.pin_s[uims_pkg::P_CTS] && !s_q.cts_p) begin
			s_d.l6c = 1'b1;
		end
		if (s_q.rts_n && !s_q.rts_p) begin
			s_d.l6r = 1'b1;
		end

		s_d.msr_d = (rd_msr ? 4'h0 : s_q.msr_d) | mdm_evt;

		// register writes
		if (reg_req.wr) begin
			case (reg_req.addr)
				uims_pkg::A_DATA: begin
					if (divisor_access) begin
						s_d.dll = reg_req.wdata;
					end
				end
				uims_pkg::A_IER: begin
					if (divisor_access) begin
						s_d.divisor_high_byte = reg_req.wdata;
					end else begin
						s_d.irq_enable_reg = reg_req.wdata;
					end
				end
				uims_pkg::A_MCR: begin
					s_d.modem_control[6:0] = reg_req.wdata[6:0];
					if (enhanced_mode) begin
						s_d.modem_control[uims_pkg::MC_PSEL] =
							reg_req.wdata[uims_pkg::MC_PSEL];
					end
				end
				uims_pkg::A_LSR: begin
					if (s_q.scratch_pad == uims_pkg::CPR_IDX) begin
						s_d.clock_prescaler = reg_req.wdata;
					end
				end
				uims_pkg::A_SPR: begin
					s_d.scratch_pad = reg_req.wdata;
				end
				default: begin
				end
			endcase
		end

		// register reads, data appears one cycle later
		if (reg_req.rd) begin
			case (reg_req.addr)
				uims_pkg::A_DATA: begin
					s_d.rdata = divisor_access ? s_q.dll : 8'h00;
				end
				uims_pkg::A_IER: begin
					if (divisor_access) begin
						s_d.rdata = s_q.divisor_high_byte;
					end else begin
						s_d.rdata = s_q.irq_enable_reg;
						if (enhanced_mode) begin
							s_d.rdata[uims_pkg::IE_SLP] = s_q.asleep;
						end else begin
							s_d.rdata[uims_pkg::IE_SPC] = s_q.asleep;
						end
					end
				end
				uims_pkg::A_ISR: begin
					s_d.rdata = {2'b00, code};
				end
				uims_pkg::A_MCR: begin
					s_d.rdata = s_q.modem_control;
				end
				uims_pkg::A_LSR: begin
					s_d.rdata = {s_q.lsr_err, tx_level == '0 && tx_shift_empty,
						tx_level == '0, s_q.lsr_flg, rx_level != '0};
				end
				uims_pkg::A_MSR: begin
					s_d.rdata = {s_q.mdm_p, s_q.msr_d};
				end
				uims_pkg::A_SPR: begin
					s_d.rdata = s_q.scratch_pad;
				end
				default: begin
					s_d.rdata = 8'h00;
				end
			endcase
		end

		// sleep: infrared needs the 16x clock, so it forbids sleep
		slp_req = enhanced_mode ? s_q.irq_enable_reg[uims_pkg::IE_SLP]
			: s_q.irq_enable_reg[uims_pkg::IE_SPC];
		slp_ok = slp_req && tx_level == '0 && tx_shift_empty
			&& s_q.pin_s[uims_pkg::P_SIN] && rx_idle && rx_level == '0
			&& !loop && s_q.msr_d == 4'h0 && code == uims_pkg::ISR_NONE
			&& !s_q.ctl[2];
		s_d.asleep = slp_ok;

		s_d.irq = code != uims_pkg::ISR_NONE;
		s_d.irq_oe = s_q.pin_s[uims_pkg::P_SEL]
			|| s_q.modem_control[uims_pkg::MC_OUTB];

		s_d.tx_line = loop || tx_serial_bit;
		s_d.dtr_n = loop || !s_q.modem_control[uims_pkg::MC_DTR];
		s_d.rts_n = loop || !s_q.modem_control[uims_pkg::MC_RTS];
		s_d.out_a = loop || s_q.modem_control[uims_pkg::MC_OUTA];
		s_d.out_b = loop || s_q.modem_control[uims_pkg::MC_OUTB];
		s_d.rx_line = loop ? tx_serial_bit : s_q.pin_s[uims_pkg::P_SIN];
		s_d.pre = s_q.modem_control[uims_pkg::MC_PSEL] ? s_q.clock_prescaler
			: uims_pkg::CPR_DIV1;
		s_d.ctl = {enhanced_mode && s_q.modem_control[uims_pkg::MC_IRDA],
			!enhanced_mode && s_q.modem_control[uims_pkg::MC_XANY],
			enhanced_mode && s_q.modem_control[uims_pkg::MC_XANY]};
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s_q <= '0;
			s_q.pin_m <= 6'h3F;
			s_q.pin_s <= 6'h3F;
			s_q.clock_prescaler <= uims_pkg::CPR_RST;
			s_q.dll <= uims_pkg::DIV_RST[7:0];
			s_q.divisor_high_byte <= uims_pkg::DIV_RST[15:8];
			s_q.cts_p <= 1'b1;
			s_q.rts_p <= 1'b1;
			s_q.tx_line <= 1'b1;
			s_q.dtr_n <= 1'b1;
			s_q.rts_n <= 1'b1;
			s_q.rx_line <= 1'b1;
			s_q.pre <= uims_pkg::CPR_DIV1;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign serial_tx_line = s_q.tx_line;
	assign local_terminal_ready_out = s_q.dtr_n;
	assign request_to_send_out = s_q.rts_n;
	assign user_output_a = s_q.out_a;
	assign user_output_b = s_q.out_b;
	assign rx_serial_to_receiver = s_q.rx_line;
	assign irq_out = s_q.irq;
	assign irq_oe = s_q.irq_oe;
	assign chan_asleep = s_q.asleep;
	assign baud_divisor = {s_q.divisor_high_byte, s_q.dll};
	assign prescale_cfg = s_q.pre;
	assign xon_any_en = s_q.ctl[0];
	assign hw_flow_en = s_q.ctl[1];
	assign irda_en = s_q.ctl[2];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	isr_idle_a: assert property (
		rd_isr && !(src1 || src2a || src2b || src3 || src4 || src5 || src6)
		|=> s_q.rdata == {2'h0, uims_pkg::ISR_NONE})
		else $error("idle source code wrong");
	lsr_clear_a: assert property (
		rd_lsr && rx_err == '0 |=> s_q.lsr_flg == 4'h0)
		else $error("line status not cleared by read");
	rx_avail_a: assert property (
		!src1 && rx_level > rx_trig && s_q.irq_enable_reg[uims_pkg::IE_RX]
		|-> code == uims_pkg::ISR_L2A)
		else $error("receive data level not reported");
	timeout_clr_a: assert property (
		rd_rhr |=> !s_q.to_flg ##1 !s_q.to_flg)
		else $error("time-out survived data read");
	msr_clear_a: assert property (
		rd_msr && mdm_evt == 4'h0 |=> s_q.msr_d == 4'h0)
		else $error("modem deltas not cleared");
	loop_out_a: assert property (
		loop |=> s_q.tx_line && s_q.dtr_n && s_q.rts_n && s_q.out_a
		&& s_q.out_b)
		else $error("loopback outputs not inactive");
	dtr_drive_a: assert property (
		!loop |=> s_q.dtr_n == !$past(s_q.modem_control[uims_pkg::MC_DTR]))
		else $error("ready output wrong level");
	sleep_wake_a: assert property (
		s_q.asleep && $rose(s_q.modem_control[uims_pkg::MC_LOOP]) |=> !s_q.asleep)
		else $error("sleep kept in loopback");
	irq_oe_a: assert property (
		s_q.pin_s[uims_pkg::P_SEL] |=> s_q.irq_oe)
		else $error("interrupt driver off with select high");
	psel_hold_a: assert property (
		reg_req.wr && reg_req.addr == uims_pkg::A_MCR && !enhanced_mode
		|=> $stable(s_q.modem_control[uims_pkg::MC_PSEL]))
		else $error("prescaler select written outside enhanced");
	irq_follow_a: assert property (
		code != uims_pkg::ISR_NONE |=> s_q.irq)
		else $error("pending source not on interrupt");

	sleep_c: cover property ($rose(s_q.asleep));
	timeout_c: cover property ($rose(s_q.to_flg));
	lvl6_c: cover property (code == uims_pkg::ISR_L6 && rd_isr);
	loop_c: cover property (loop && |s_q.msr_d);
endmodule

/* File: testbench/uims_peer.sv */
`timescale 1ns/1ps
module uims_peer (
	input logic clk_sys,
	input logic [4:0] want,
	input logic [1:0] lag,
	output logic serial_rx_line,
	output logic clear_to_send_in_n,
	output logic data_set_ready_in_n,
	output logic bell_indicator_in,
	output logic carrier_detect_in
);
	// pin order: carrier, ring, ready, clear, serial; all idle high
	logic [4:0] pins_q = 5'h1F;
	logic [1:0] wait_q = 2'h0;
	assign {carrier_detect_in, bell_indicator_in, data_set_ready_in_n,
		clear_to_send_in_n, serial_rx_line} = pins_q;
	// a slow modem lets its lines follow the request some cycles late
	always @(posedge clk_sys) begin
		if (pins_q != want && wait_q < lag) begin
			wait_q <= wait_q + 2'h1;
		end else begin
			pins_q <= want;
			wait_q <= 2'h0;
		end
	end
endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk_sys = 1'h0, nrst = 1'h0;
	uims_pkg::uims_req_t reg_req = '0;
	uims_pkg::uims_rxerr_t rx_err = '0;
	logic divisor_access = 1'h0, enhanced_mode = 1'h0, fifo_mode = 1'h0;
	logic nine_bit_mode = 1'h0, nine_bit_addr_irq_en = 1'h0;
	logic ext_trig_en = 1'h0, inband_rx_en = 1'h0, special_det_en = 1'h0;
	logic [7:0] rx_level = 8'h00, rx_trig = 8'h04;
	logic [7:0] tx_level = 8'h08, tx_trig = 8'h04;
	logic tx_shift_empty = 1'h1, tx_serial_bit = 1'h1;
	logic rx_idle = 1'h1, rx_push = 1'h0;
	logic [15:0] char_ticks = 16'h0004;
	logic stop_char_evt = 1'h0, second_stop_char_evt = 1'h0;
	logic special_char_evt = 1'h0, irq_drive_select = 1'h0;
	logic [4:0] want = 5'h1F;
	logic [1:0] lag = 2'h0;
	logic serial_rx_line, clear_to_send_in_n, data_set_ready_in_n;
	logic bell_indicator_in, carrier_detect_in;
	logic [7:0] reg_rdata, prescale_cfg;
	logic serial_tx_line, local_terminal_ready_out, request_to_send_out;
	logic user_output_a, user_output_b, rx_serial_to_receiver;
	logic irq_out, irq_oe, chan_asleep, xon_any_en, hw_flow_en, irda_en;
	logic [15:0] baud_divisor;
	int mismatches = 0;
	int total_checks = 0;

	uims_core #(.LW(8)) uims_core_i (
		.clk_sys, .nrst, .reg_req, .divisor_access, .reg_rdata,
		.enhanced_mode, .fifo_mode, .nine_bit_mode, .nine_bit_addr_irq_en,
		.ext_trig_en, .inband_rx_en, .special_det_en, .rx_level, .rx_trig,
		.tx_level, .tx_trig, .tx_shift_empty, .tx_serial_bit, .rx_idle,
		.rx_push, .rx_err, .char_ticks, .stop_char_evt,
		.second_stop_char_evt, .special_char_evt, .serial_rx_line,
		.clear_to_send_in_n, .data_set_ready_in_n, .bell_indicator_in,
		.carrier_detect_in, .irq_drive_select, .serial_tx_line,
		.local_terminal_ready_out, .request_to_send_out, .user_output_a,
		.user_output_b, .rx_serial_to_receiver, .irq_out, .irq_oe,
		.chan_asleep, .baud_divisor, .prescale_cfg, .xon_any_en,
		.hw_flow_en, .irda_en
	);

	uims_peer uims_peer_i (
		.clk_sys, .want, .lag, .serial_rx_line, .clear_to_send_in_n,
		.data_set_ready_in_n, .bell_indicator_in, .carrier_detect_in
	);

	always #25 clk_sys = ~clk_sys;

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value at %0t ns: saw %h, wanted %h", $time, s, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic w(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_req.addr = a;
		reg_req.wdata = d;
		reg_req.wr = 1'h1;
		@(negedge clk_sys);
		reg_req.wr = 1'h0;
	endtask

	// read data lands on the edge that takes the request
	task automatic rd(input logic [2:0] a);
		@(negedge clk_sys);
		reg_req.addr = a;
		reg_req.rd = 1'h1;
		@(negedge clk_sys);
		reg_req.rd = 1'h0;
	endtask

	task automatic rc(input logic [2:0] a, input logic [7:0] e);
		rd(a);
		chk(reg_rdata, e);
	endtask

	task automatic irq_source_reg(input logic [5:0] c);
		rc(3'h2, {2'h0, c});
	endtask

	task automatic pls(input logic [3:0] e);
		@(negedge clk_sys);
		rx_err = e;
		@(negedge clk_sys);
		rx_err = '0;
	endtask

	// the run needs about 350 cycles; nearly thirty times that means a hang
	initial begin
		repeat (10000) @(posedge clk_sys);
		mismatches++;
		wrap_up;
	end

	initial begin
		cyc(5);
		nrst = 1'h1;
		chk(baud_divisor, uims_pkg::DIV_RST);
		chk({local_terminal_ready_out, request_to_send_out}, 2'h3);
		irq_source_reg(uims_pkg::ISR_NONE);
		rc(3'h3, 8'h00);
		divisor_access = 1'h1;
		w(3'h0, 8'h34);
		w(3'h1, 8'h12);
		cyc(2);
		chk(baud_divisor, 16'h1234);
		rc(3'h0, 8'h34);
		divisor_access = 1'h0;
		w(3'h7, 8'hA5);
		rc(3'h7, 8'hA5);
		w(3'h4, 8'h80);
		cyc(2);
		chk(prescale_cfg, uims_pkg::CPR_DIV1);
		enhanced_mode = 1'h1;
		w(3'h4, 8'h80);
		cyc(2);
		chk(prescale_cfg, uims_pkg::CPR_RST);
		w(3'h7, uims_pkg::CPR_IDX);
		w(3'h5, 8'h1B);
		cyc(2);
		chk(prescale_cfg, 8'h1B);
		w(3'h4, 8'h20);
		cyc(2);
		chk({xon_any_en, hw_flow_en}, 2'h2);
		w(3'h4, 8'h40);
		cyc(2);
		chk(irda_en, 1'h1);
		enhanced_mode = 1'h0;
		w(3'h4, 8'h20);
		cyc(2);
		chk({xon_any_en, hw_flow_en}, 2'h1);
		w(3'h4, 8'h03);
		cyc(2);
		chk({local_terminal_ready_out, request_to_send_out}, 2'h0);
		w(3'h4, 8'h00);
		cyc(2);
		chk({local_terminal_ready_out, request_to_send_out}, 2'h3);
		// status error outranks data available
		w(3'h1, 8'h05);
		rx_level = 8'h05;
		pls(4'h2);
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L1);
		rc(3'h5, 8'h89);
		irq_source_reg(uims_pkg::ISR_L2A);
		rx_level = 8'h04;
		cyc(2);
		irq_source_reg(uims_pkg::ISR_NONE);
		rx_level = 8'h00;
		nine_bit_mode = 1'h1;
		w(3'h1, 8'h04);
		pls(4'h2);
		cyc(2);
		irq_source_reg(uims_pkg::ISR_NONE);
		rd(3'h5);
		w(3'h1, 8'h08);
		pls(4'h2);
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L1);
		rc(3'h5, 8'h88);
		nine_bit_addr_irq_en = 1'h1;
		pls(4'h4);
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L1);
		rc(3'h5, 8'h04);
		nine_bit_mode = 1'h0;
		fifo_mode = 1'h1;
		rx_trig = 8'h08;
		rx_level = 8'h01;
		w(3'h1, 8'h01);
		rx_push = 1'h1;
		@(negedge clk_sys);
		rx_push = 1'h0;
		cyc(8);
		irq_source_reg(uims_pkg::ISR_NONE);
		cyc(12);
		irq_source_reg(uims_pkg::ISR_L2B);
		rd(3'h0);
		irq_source_reg(uims_pkg::ISR_NONE);
		rx_level = 8'h00;
		fifo_mode = 1'h0;
		rx_trig = 8'h04;
		w(3'h1, 8'h02);
		tx_level = 8'h02;
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L3);
		irq_source_reg(uims_pkg::ISR_NONE);
		tx_level = 8'h08;
		cyc(1);
		tx_level = 8'h02;
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L3);
		tx_level = 8'h08;
		cyc(2);
		irq_source_reg(uims_pkg::ISR_NONE);
		ext_trig_en = 1'h1;
		tx_trig = 8'h00;
		tx_shift_empty = 1'h0;
		tx_level = 8'h00;
		cyc(3);
		irq_source_reg(uims_pkg::ISR_NONE);
		tx_shift_empty = 1'h1;
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L3);
		irq_source_reg(uims_pkg::ISR_NONE);
		w(3'h1, 8'h08);
		want = 5'h1D;
		cyc(6);
		irq_source_reg(uims_pkg::ISR_L4);
		rc(3'h6, 8'h11);
		irq_source_reg(uims_pkg::ISR_NONE);
		lag = 2'h2;
		want = 5'h15;
		cyc(8);
		rc(3'h6, 8'h50);
		want = 5'h1D;
		cyc(8);
		rc(3'h6, 8'h14);
		lag = 2'h0;
		want = 5'h1F;
		cyc(6);
		rc(3'h6, 8'h01);
		enhanced_mode = 1'h1;
		w(3'h1, 8'hC0);
		want = 5'h1D;
		cyc(6);
		want = 5'h1F;
		cyc(6);
		irq_source_reg(uims_pkg::ISR_L6);
		irq_source_reg(uims_pkg::ISR_NONE);
		w(3'h4, 8'h02);
		w(3'h4, 8'h00);
		cyc(2);
		irq_source_reg(uims_pkg::ISR_L6);
		irq_source_reg(uims_pkg::ISR_NONE);
		rd(3'h6);
		w(3'h1, 8'h20);
		inband_rx_en = 1'h1;
		special_det_en = 1'h1;
		for (int k = 0; k < 3; k++) begin
			nine_bit_mode = (k == 2);
			{stop_char_evt, second_stop_char_evt, special_char_evt} = 3'h4 >> k;
			@(negedge clk_sys);
			{stop_char_evt, second_stop_char_evt, special_char_evt} = 3'h0;
			cyc(2);
			irq_source_reg(uims_pkg::ISR_L5);
			irq_source_reg(uims_pkg::ISR_NONE);
		end
		nine_bit_mode = 1'h0;
		// loopback: pins parked high, modem status fed from control bits
		w(3'h1, 8'h08);
		w(3'h4, 8'h1F);
		cyc(4);
		chk({serial_tx_line, local_terminal_ready_out, request_to_send_out,
			user_output_a, user_output_b}, 5'h1F);
		rd(3'h6);
		rc(3'h6, 8'hF0);
		w(3'h4, 8'h10);
		cyc(4);
		chk({user_output_a, user_output_b}, 2'h3);
		irq_source_reg(uims_pkg::ISR_L4);
		rc(3'h6, 8'h0F);
		tx_serial_bit = 1'h0;
		cyc(3);
		chk(rx_serial_to_receiver, 1'h0);
		want = 5'h1E;
		tx_serial_bit = 1'h1;
		cyc(4);
		chk(rx_serial_to_receiver, 1'h1);
		want = 5'h1F;
		w(3'h4, 8'h00);
		cyc(4);
		rd(3'h6);
		w(3'h1, 8'h01);
		rx_level = 8'h05;
		cyc(3);
		chk({irq_out, irq_oe}, 2'h2);
		w(3'h4, 8'h08);
		cyc(2);
		chk(irq_oe, 1'h1);
		w(3'h4, 8'h00);
		irq_drive_select = 1'h1;
		cyc(4);
		chk({irq_out, irq_oe}, 2'h3);
		w(3'h1, 8'h00);
		cyc(2);
		chk(irq_out, 1'h0);
		rx_level = 8'h00;
		irq_drive_select = 1'h0;
		w(3'h1, 8'h10);
		cyc(3);
		chk(chan_asleep, 1'h1);
		rc(3'h1, 8'h10);
		want = 5'h1E;
		cyc(5);
		chk(chan_asleep, 1'h0);
		rc(3'h1, 8'h00);
		want = 5'h1F;
		cyc(5);
		chk(chan_asleep, 1'h1);
		// entering loopback while asleep must wake the channel
		w(3'h4, 8'h10);
		cyc(2);
		chk(chan_asleep, 1'h0);
		w(3'h4, 8'h00);
		cyc(3);
		chk(chan_asleep, 1'h1);
		w(3'h4, 8'h40);
		cyc(2);
		chk(chan_asleep, 1'h0);
		w(3'h4, 8'h00);
		cyc(3);
		chk(chan_asleep, 1'h1);
		w(3'h1, 8'h00);
		cyc(2);
		chk(chan_asleep, 1'h0);
		wrap_up;
	end
endmodule
